// ==== hw/jnvc_top.v ====
// Purpose: TAP controller and instruction decode for nonvolatile programming
// Assumes: tck, tms, tdi are pins sampled by clk (tck far slower than clk)
// Notes: tdo changes after each falling tck edge; storage modelled in flops
`timescale 1ns/1ps
`default_nettype none
`include "jnvc_defines.vh"
// Operation
// - Signature-read loads stored signature into 32-bit shift register on the scan path.
// - Signature-program writes the signature shift register into the stored signature.
// - Erase and program instructions act only while programming mode is on.
// - Program-disable clears programming mode.
// - Test-Logic-Reset also clears programming mode.
// - Reset instruction returns device to near power-on state.
// - Erase-completion-flag instruction clears the done flag.
// - Configuration-verify reads back the addressed column for host comparison.
// - Configuration-erase wipes the whole array on second RTI tck edge.
// - Configuration-address captures a column address for later program or read.
// - Data-shift puts the configuration data register on the scan path.
// - Configuration-program writes shifted data to addressed column on second RTI edge.
// - Program-completion-flag instruction sets the done flag.
// - Opcodes are eight bits with fixed codes.
// - Configuration address register is four bits.
// - Configuration data register is fifty-six bits.
// - Signature shift register is thirty-two bits.
module jnvc_top
#(
	parameter [`JNVC_ID_LEN-1:0] ID_CODE = 32'h00000001 // Arbitrary value
)
(
	input wire clk,
	input wire rstn,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo,
	output reg tdo_oe,
	output reg prog_mode,
	output reg done_flag,
	output reg device_reset,
	output reg [`JNVC_SIG_LEN-1:0] user_signature_word
);
	// TAP states, one-hot
	localparam [15:0] ST_TLR = 16'h0001;
	localparam [15:0] ST_RTI = 16'h0002;
	localparam [15:0] ST_SDRS = 16'h0004;
	localparam [15:0] ST_CDR = 16'h0008;
	localparam [15:0] ST_SDR = 16'h0010;
	localparam [15:0] ST_E1DR = 16'h0020;
	localparam [15:0] ST_PDR = 16'h0040;
	localparam [15:0] ST_E2DR = 16'h0080;
	localparam [15:0] ST_UDR = 16'h0100;
	localparam [15:0] ST_SIRS = 16'h0200;
	localparam [15:0] ST_CIR = 16'h0400;
	localparam [15:0] ST_SIR = 16'h0800;
	localparam [15:0] ST_E1IR = 16'h1000;
	localparam [15:0] ST_PIR = 16'h2000;
	localparam [15:0] ST_E2IR = 16'h4000;
	localparam [15:0] ST_UIR = 16'h8000;

	wire tck_s;
	wire tms_s;
	wire tdi_s;
	reg tck_d_r;
	reg [15:0] state_r;
	reg [15:0] state_nxt;
	reg [`JNVC_IR_LEN-1:0] ir_sh_r;
	reg [`JNVC_IR_LEN-1:0] ir_r;
	reg bypass_r;
	reg [`JNVC_ID_LEN-1:0] id_sh_r;
	reg [`JNVC_SIG_LEN-1:0] sig_sh_r;
	reg [`JNVC_ADDR_LEN-1:0] addr_sh_r;
	reg [`JNVC_ADDR_LEN-1:0] addr_r;
	reg [`JNVC_DATA_LEN-1:0] data_sh_r;
	reg [1:0] rti_cnt_r;
	reg cfg_wr;
	reg cfg_erase;
	reg dr_out;
	wire [`JNVC_DATA_LEN-1:0] col_rdata;
	wire tck_rise;
	wire tck_fall;
	wire fire;
	wire is_sig;
	wire is_id;
	wire is_addr;
	wire is_data;

	jnvc_sync u_sync_tck (.clk(clk), .rstn(rstn), .din(tck), .dout(tck_s));
	jnvc_sync u_sync_tms (.clk(clk), .rstn(rstn), .din(tms), .dout(tms_s));
	jnvc_sync u_sync_tdi (.clk(clk), .rstn(rstn), .din(tdi), .dout(tdi_s));

	jnvc_cfg_mem u_mem
	(
		.clk(clk),
		.rstn(rstn),
		.wr_en(cfg_wr),
		.erase_all(cfg_erase),
		.addr(addr_r),
		.wdata(data_sh_r),
		.rdata(col_rdata)
	);

	// Edge detect on the synchronised clock only
	assign tck_rise = tck_s & ~tck_d_r;
	assign tck_fall = ~tck_s & tck_d_r;

	// Data register selection by current instruction
	assign is_sig = (ir_r == `JNVC_OP_SIG_READ);
	assign is_id = (ir_r == `JNVC_OP_IDCODE);
	assign is_addr = (ir_r == `JNVC_OP_CFG_ADDRESS);
	assign is_data = (ir_r == `JNVC_OP_CFG_SHIFT) || (ir_r == `JNVC_OP_CFG_VERIFY);

	// Action strobe: second rising tck in RTI, once per stay
	assign fire = tck_rise && state_r == ST_RTI
		&& rti_cnt_r == (`JNVC_RTI_FIRE_EDGE - 2'h1);

	// TAP next state
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_TLR: state_nxt = tms_s ? ST_TLR : ST_RTI;
			ST_RTI: state_nxt = tms_s ? ST_SDRS : ST_RTI;
			ST_SDRS: state_nxt = tms_s ? ST_SIRS : ST_CDR;
			ST_CDR: state_nxt = tms_s ? ST_E1DR : ST_SDR;
			ST_SDR: state_nxt = tms_s ? ST_E1DR : ST_SDR;
			ST_E1DR: state_nxt = tms_s ? ST_UDR : ST_PDR;
			ST_PDR: state_nxt = tms_s ? ST_E2DR : ST_PDR;
			ST_E2DR: state_nxt = tms_s ? ST_UDR : ST_SDR;
			ST_UDR: state_nxt = tms_s ? ST_SDRS : ST_RTI;
			ST_SIRS: state_nxt = tms_s ? ST_TLR : ST_CIR;
			ST_CIR: state_nxt = tms_s ? ST_E1IR : ST_SIR;
			ST_SIR: state_nxt = tms_s ? ST_E1IR : ST_SIR;
			ST_E1IR: state_nxt = tms_s ? ST_UIR : ST_PIR;
			ST_PIR: state_nxt = tms_s ? ST_E2IR : ST_PIR;
			ST_E2IR: state_nxt = tms_s ? ST_UIR : ST_SIR;
			ST_UIR: state_nxt = tms_s ? ST_SDRS : ST_RTI;
			default: state_nxt = ST_TLR;
		endcase
	end

	// Action decode; gated by programming mode so nothing fires outside it
	always @*
	begin
		cfg_wr = fire && prog_mode && ir_r == `JNVC_OP_CFG_PROGRAM;
		cfg_erase = fire && prog_mode && ir_r == `JNVC_OP_CFG_ERASE;
	end

	// Serial output mux for the selected register
	always @*
	begin
		if (state_r == ST_SIR)
			dr_out = ir_sh_r[0];
		else if (is_sig)
			dr_out = sig_sh_r[0];
		else if (is_id)
			dr_out = id_sh_r[0];
		else if (is_addr)
			dr_out = addr_sh_r[0];
		else if (is_data)
			dr_out = data_sh_r[0];
		else
			dr_out = bypass_r;
	end

	// TAP state and clock history
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tck_d_r <= 1'b0;
			state_r <= ST_TLR;
		end
		else
		begin
			tck_d_r <= tck_s;
			if (tck_rise)
				state_r <= state_nxt;
		end
	end

	// Instruction register; TLR forces IDCODE default
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ir_sh_r <= `JNVC_IR_CAPTURE;
			ir_r <= `JNVC_OP_IDCODE;
		end
		else if (tck_rise)
		begin
			if (state_r == ST_TLR)
				ir_r <= `JNVC_OP_IDCODE;
			else if (state_r == ST_CIR)
				ir_sh_r <= `JNVC_IR_CAPTURE;
			else if (state_r == ST_SIR)
				ir_sh_r <= {tdi_s, ir_sh_r[`JNVC_IR_LEN-1:1]};
			else if (state_r == ST_UIR)
				ir_r <= ir_sh_r;
		end
	end

	// Data registers: capture and shift
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bypass_r <= 1'b0;
			id_sh_r <= {`JNVC_ID_LEN{1'b0}};
			sig_sh_r <= {`JNVC_SIG_LEN{1'b0}};
			addr_sh_r <= {`JNVC_ADDR_LEN{1'b0}};
			data_sh_r <= {`JNVC_DATA_LEN{1'b0}};
		end
		else if (tck_rise && state_r == ST_CDR)
		begin
			bypass_r <= 1'b0;
			id_sh_r <= ID_CODE;
			if (is_sig)
				sig_sh_r <= user_signature_word;
			if (ir_r == `JNVC_OP_CFG_VERIFY)
				data_sh_r <= col_rdata;
		end
		else if (tck_rise && state_r == ST_SDR)
		begin
			bypass_r <= tdi_s;
			if (is_id)
				id_sh_r <= {tdi_s, id_sh_r[`JNVC_ID_LEN-1:1]};
			if (is_sig)
				sig_sh_r <= {tdi_s, sig_sh_r[`JNVC_SIG_LEN-1:1]};
			if (is_addr)
				addr_sh_r <= {tdi_s, addr_sh_r[`JNVC_ADDR_LEN-1:1]};
			if (is_data)
				data_sh_r <= {tdi_s, data_sh_r[`JNVC_DATA_LEN-1:1]};
		end
	end

	// Column address latched at Update-DR
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			addr_r <= {`JNVC_ADDR_LEN{1'b0}};
		else if (tck_rise && state_r == ST_UDR && is_addr)
			addr_r <= addr_sh_r;
	end

	// Count rising tck edges spent in RTI, saturating at the fire edge
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rti_cnt_r <= 2'h0;
		else if (tck_rise)
		begin
			if (state_r != ST_RTI)
				rti_cnt_r <= 2'h0;
			else if (rti_cnt_r != `JNVC_RTI_FIRE_EDGE)
				rti_cnt_r <= rti_cnt_r + 2'h1;
		end
	end

	// Programming mode, done flag, signature store and reset pulse
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			prog_mode <= 1'b0;
			done_flag <= 1'b0;
			device_reset <= 1'b0;
			user_signature_word <= `JNVC_ERASED_SIG;
		end
		else
		begin
			device_reset <= 1'b0;
			// Level test, so mode drops on entry to reset state, not a tck later
			if (state_r == ST_TLR)
				prog_mode <= 1'b0;
			else if (tck_rise && state_r == ST_UIR)
			begin
				if (ir_sh_r == `JNVC_OP_PROG_ENABLE)
					prog_mode <= 1'b1;
				else if (ir_sh_r == `JNVC_OP_PROG_DISABLE)
					prog_mode <= 1'b0;
				else if (ir_sh_r == `JNVC_OP_RESET)
					device_reset <= 1'b1;
			end
			if (fire && prog_mode)
			begin
				if (ir_r == `JNVC_OP_PROG_DONE)
					done_flag <= 1'b1;
				else if (ir_r == `JNVC_OP_ERASE_DONE)
					done_flag <= 1'b0;
				else if (ir_r == `JNVC_OP_SIG_PROGRAM)
					user_signature_word <= sig_sh_r;
			end
		end
	end

	// TDO updates on falling tck, driven only in shift states
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo <= dr_out;
			tdo_oe <= (state_r == ST_SDR) || (state_r == ST_SIR);
		end
	end
endmodule
`default_nettype wire

// ==== hw/jnvc_defines.vh ====
// Purpose: constants for the JTAG nonvolatile configuration programming block
// Assumes: 8-bit instruction register, TCK sampled by the 100 MHz system clock
// Notes: opcodes, register lengths and erased patterns
`ifndef JNVC_DEFINES_VH
`define JNVC_DEFINES_VH

`define JNVC_IR_LEN 8
`define JNVC_OP_EXTEST 8'h00
`define JNVC_OP_PROG_ENABLE 8'h15
`define JNVC_OP_IDCODE 8'h16
`define JNVC_OP_SIG_READ 8'h17
`define JNVC_OP_SIG_PROGRAM 8'h1a
`define JNVC_OP_SAMPLE 8'h1c
`define JNVC_OP_PROG_DISABLE 8'h1e
`define JNVC_OP_RESET 8'h22
`define JNVC_OP_ERASE_DONE 8'h24
`define JNVC_OP_CFG_VERIFY 8'h28
`define JNVC_OP_CFG_ERASE 8'h29
`define JNVC_OP_CFG_ADDRESS 8'h2b
`define JNVC_OP_CFG_SHIFT 8'h2d
`define JNVC_OP_CFG_PROGRAM 8'h2e
`define JNVC_OP_PROG_DONE 8'h2f
`define JNVC_OP_BYPASS 8'hff

`define JNVC_ADDR_LEN 4
`define JNVC_DATA_LEN 56
`define JNVC_SIG_LEN 32
`define JNVC_ID_LEN 32
`define JNVC_COLUMNS 16
`define JNVC_IR_CAPTURE 8'h01
`define JNVC_ERASED_COL 56'hffffffffffffff
`define JNVC_ERASED_SIG 32'hffffffff

// Rising TCK edges in Run-Test-Idle before an action fires
`define JNVC_RTI_FIRE_EDGE 2'h2

`endif

// ==== hw/jnvc_sync.v ====
// Purpose: two-flop synchroniser for one pin
// Assumes: input asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module jnvc_sync
(
	input wire clk,
	input wire rstn,
	input wire din,
	output reg dout
);
	reg meta_r;

	// Plain double register
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ==== hw/jnvc_cfg_mem.v ====
// Purpose: nonvolatile configuration column store, 16 x 56
// Assumes: single write port, registered read
// Notes: erase sets every column to the erased pattern
`timescale 1ns/1ps
`default_nettype none
`include "jnvc_defines.vh"
module jnvc_cfg_mem
(
	input wire clk,
	input wire rstn,
	input wire wr_en,
	input wire erase_all,
	input wire [`JNVC_ADDR_LEN-1:0] addr,
	input wire [`JNVC_DATA_LEN-1:0] wdata,
	output reg [`JNVC_DATA_LEN-1:0] rdata
);
	reg [`JNVC_DATA_LEN-1:0] mem_r [0:`JNVC_COLUMNS-1];
	integer i;

	// Erase wins over a write in the same cycle; read data registered
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata <= `JNVC_ERASED_COL;
			for (i = 0; i < `JNVC_COLUMNS; i = i + 1)
				mem_r[i] <= `JNVC_ERASED_COL;
		end
		else
		begin
			if (erase_all)
			begin
				for (i = 0; i < `JNVC_COLUMNS; i = i + 1)
					mem_r[i] <= `JNVC_ERASED_COL;
			end
			else if (wr_en)
				mem_r[addr] <= wdata;
			rdata <= mem_r[addr];
		end
	end
endmodule
`default_nettype wire

// ==== verification/jnvc_monitor.sv ====
// Purpose: port checker for jnvc_top
// Assumes: tck far slower than clk, sync delay of a few clk
// Notes: windows of two clk cover the edge-detect latency
`timescale 1ns/1ps
`default_nettype none
module jnvc_monitor
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic prog_mode,
	input wire logic done_flag,
	input wire logic device_reset,
	input wire logic [31:0] user_signature_word
);
	// Every check runs on the system clock
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_RST_PULSE: assert property (device_reset |=> !device_reset [*8])
		else $error("reset pulse repeats");
	AST_RST_QUIET: assert property (device_reset |-> !tdo_oe && $stable(prog_mode))
		else $error("reset pulse in shift or mode changed");
	AST_PM_EDGE: assert property ($changed(prog_mode) |-> $past(tck, 2))
		else $error("mode moved off a rising tck");
	AST_DONE_PM: assert property ($changed(done_flag) |-> $past(prog_mode) && $past(tck, 2))
		else $error("done flag moved outside program mode");
	AST_SIG_PM: assert property ($changed(user_signature_word) |-> $past(prog_mode))
		else $error("signature moved outside program mode");
	AST_TDO_FALL: assert property (tdo_oe && $changed(tdo) |-> !$past(tck, 2))
		else $error("tdo moved off a falling tck");
	AST_OE_FALL: assert property ($changed(tdo_oe) |-> !$past(tck, 2))
		else $error("tdo enable moved off a falling tck");
	AST_ACT_IDLE: assert property ($changed(done_flag) || $changed(user_signature_word)
		|-> !tdo_oe)
		else $error("store changed during a shift");
endmodule
`default_nettype wire

// ==== verification/jnvc_host.sv ====
// Purpose: JTAG host model driving the test port pins
// Assumes: tck period 125 ns, free of the system clock
// Notes: tck stands low between scans; tdi idles high
`timescale 1ns/1ps
`default_nettype none
module jnvc_host
(
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo
);
	// Pins idle with tms high so the port rests in reset
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One tck period; tdo read just before the rise
	task automatic step(input logic m, input logic v, output logic o);
		tms <= m;
		tdi <= v;
		#62.5;
		o = tdo;
		tck <= 1'b1;
		#62.5;
		tck <= 1'b0;
	endtask

	// Scan from idle and back, LSB first
	task automatic scan(input logic ir, input int n, input logic [55:0] din,
		output logic [55:0] dout);
		logic o;
		dout = 56'h0;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask

	// Rising edges spent in Run-Test-Idle
	task automatic idle(input int k);
		logic o;
		repeat (k) step(1'b0, 1'b1, o);
	endtask

	// Five tms-high edges reach Test-Logic-Reset, then back to idle
	task automatic tlr;
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
endmodule
`default_nettype wire

// ==== verification/jnvc_top_test.sv ====
// Purpose: self-checking bench for jnvc_top
// Assumes: a scan that leaves idle spends one idle edge first
// Notes: actions are judged after the next scan lands
`timescale 1ns/1ps
`default_nettype none
`include "jnvc_defines.vh"
module jnvc_top_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	wire tck;
	wire tms;
	wire tdi;
	wire tdo;
	wire tdo_oe;
	wire prog_mode;
	wire done_flag;
	wire device_reset;
	wire tdo_pin;
	wire [31:0] sig_word;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n_rst = 0;
	logic [55:0] d;
	localparam logic [55:0] COL = 56'h123456789abcde;

	jnvc_top jnvc_top_inst (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo(tdo), .tdo_oe(tdo_oe), .prog_mode(prog_mode), .done_flag(done_flag),
		.device_reset(device_reset), .user_signature_word(sig_word));
	jnvc_host jnvc_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));

	// Pull-up on the released line, so a late enable shows as ones
	assign tdo_pin = tdo_oe ? tdo : 1'b1;

	// System clock, 10 ns
	initial
	begin
		forever #5 clk = ~clk;
	end

	// Count reset pulses seen
	always @(posedge clk)
		if (device_reset === 1'b1)
			n_rst <= n_rst + 1;

	task automatic check(input logic [55:0] got, input logic [55:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ir(input logic [7:0] op);
		jnvc_host_inst.scan(1'b1, 8, {48'h0, op}, d);
		check(d & 56'hff, 56'h01);
	endtask

	task automatic dr(input int n, input logic [55:0] v);
		jnvc_host_inst.scan(1'b0, n, v, d);
	endtask

	// Identity after reset, then bypass
	task automatic t_ident;
		dr(32, 56'h0);
		check(d, 56'h1);
		ir(`JNVC_OP_BYPASS);
		dr(2, 56'h1);
		check(d, 56'h2);
	endtask

	// Signature program without program mode leaves the store alone
	task automatic t_refuse;
		ir(`JNVC_OP_PROG_DONE);
		ir(`JNVC_OP_SIG_PROGRAM);
		jnvc_host_inst.idle(2);
		ir(`JNVC_OP_BYPASS);
		check(56'(done_flag), 56'h0);
		check(56'(sig_word), `JNVC_ERASED_SIG);
	endtask

	// Erase, address, load, program on the second idle edge only
	task automatic t_column;
		ir(`JNVC_OP_PROG_ENABLE);
		check(56'(prog_mode), 56'h1);
		ir(`JNVC_OP_CFG_ERASE);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_CFG_ADDRESS);
		dr(4, 56'h9);
		ir(`JNVC_OP_CFG_SHIFT);
		dr(56, COL);
		ir(`JNVC_OP_CFG_PROGRAM);
		ir(`JNVC_OP_CFG_VERIFY);
		dr(56, 56'h0);
		check(d, `JNVC_ERASED_COL);
		ir(`JNVC_OP_CFG_SHIFT);
		dr(56, COL);
		check(d, 56'h0);
		ir(`JNVC_OP_CFG_PROGRAM);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_CFG_VERIFY);
		dr(56, 56'h0);
		check(d, COL);
		ir(`JNVC_OP_CFG_ADDRESS);
		dr(4, 56'h3);
		ir(`JNVC_OP_CFG_VERIFY);
		dr(56, 56'h0);
		check(d, `JNVC_ERASED_COL);
		ir(`JNVC_OP_CFG_ERASE);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_CFG_ADDRESS);
		dr(4, 56'h9);
		ir(`JNVC_OP_CFG_VERIFY);
		dr(56, 56'h0);
		check(d, `JNVC_ERASED_COL);
	endtask

	// Done flag set and cleared, signature written and read
	task automatic t_flags;
		ir(`JNVC_OP_PROG_DONE);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_SIG_READ);
		check(56'(done_flag), 56'h1);
		dr(32, 56'h5a5aa5c3);
		check(d, `JNVC_ERASED_SIG);
		ir(`JNVC_OP_SIG_PROGRAM);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_ERASE_DONE);
		check(56'(sig_word), 56'h5a5aa5c3);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_SIG_READ);
		check(56'(done_flag), 56'h0);
		dr(32, 56'h0);
		check(d, 56'h5a5aa5c3);
	endtask

	// Leaving program mode two ways, then the reset opcode
	task automatic t_leave;
		ir(`JNVC_OP_PROG_DISABLE);
		check(56'(prog_mode), 56'h0);
		ir(`JNVC_OP_PROG_DONE);
		jnvc_host_inst.idle(1);
		ir(`JNVC_OP_PROG_ENABLE);
		check(56'(done_flag), 56'h0);
		check(56'(prog_mode), 56'h1);
		jnvc_host_inst.tlr();
		check(56'(prog_mode), 56'h0);
		dr(32, 56'h0);
		check(d, 56'h1);
		ir(`JNVC_OP_RESET);
		check(56'(n_rst), 56'h1);
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Reset, then the scenarios in turn
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		#2; // Keeps every host pin edge off a clk edge
		jnvc_host_inst.idle(1);
		t_ident;
		t_refuse;
		t_column;
		t_flags;
		t_leave;
		print_verdict;
	end

	// Hang guard, well past the longest expected run
	initial
	begin
		#400000;
		n_mismatch++;
		print_verdict;
	end
endmodule

bind jnvc_top jnvc_monitor jnvc_monitor_inst (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms),
	.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .prog_mode(prog_mode), .done_flag(done_flag),
	.device_reset(device_reset), .user_signature_word(user_signature_word));
`default_nettype wire
